/* File: core/gyc_regs.svh */
// Register offsets, field positions, reset values and timing constants of the rate control block.
// Assumes the includer works with byte addresses of seven bits and a 100 MHz clock.
`ifndef GYC_REGS_SVH
`define GYC_REGS_SVH
// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define GYC_A_RATE  7'h04
`define GYC_A_ANGLE 7'h0e
`define GYC_A_OFF   7'h14
`define GYC_A_SCALE 7'h16
`define GYC_A_DAC   7'h30
`define GYC_A_SMPL  7'h36
`define GYC_A_SENS  7'h38
`define GYC_A_SLP   7'h3a
`define GYC_A_CMD   7'h3e
// ----------------------------------------
// Reset and factory values
// ----------------------------------------
`define GYC_SMPL_RST 8'h01
`define GYC_SENS_RST 16'h0402
`define GYC_OFF_FACT 12'h000
`define GYC_SCL_FACT 12'h800
// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define GYC_C_NULL   0
`define GYC_C_REST   1
`define GYC_C_DAC    2
`define GYC_C_FLASH  3
`define GYC_C_SRST   7
`define GYC_SP_TB    7
`define GYC_SN_BW    7
`define GYC_RG_320   3'h4
`define GYC_RG_160   3'h2
`define GYC_RG_80    3'h1
`define GYC_MIN_M160 4'h2
`define GYC_MIN_M80  4'h4
`define GYC_MAX_M    4'h7
`define GYC_LP_MULT  8
`define GYC_CAL_SH   11
`define GYC_FRAME    5'h10
// ----------------------------------------
// Timing
// ----------------------------------------
`define GYC_CLK_MHZ   100
`define GYC_TB_FAST_US 1953
`define GYC_TB_SLOW_US 60540
`define GYC_FAST_SPS  2048
`define GYC_FLASH_MS  50
`define GYC_SLP_LSB_MS 500
`endif

/* File: core/gyc_pkg.sv */
// Types shared by the rate control block: pipeline states and the state record.
// Assumes nothing of its surroundings.
package gyc_pkg;
    typedef enum logic [2:0] {GYC_CLR, GYC_IDLE, GYC_S1, GYC_S2, GYC_CAL} gyc_state_e;
    typedef struct packed {
        logic [2:0]  sck;
        logic [2:0]  csn;
        logic [1:0]  mosi;
        logic [1:0]  rpin;
        logic [4:0]  bits;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [15:0] rdw;
        logic [11:0] off;
        logic [11:0] scl;
        logic [11:0] dac;
        logic [11:0] dacl;
        logic [7:0]  smpl;
        logic [15:0] sens;
        logic [7:0]  slp;
        logic [11:0] nv_off;
        logic [11:0] nv_scl;
        logic [7:0]  nv_smpl;
        logic [15:0] nv_sens;
        logic [31:0] fcnt;
        logic        fpend;
        logic [31:0] tcnt;
        logic [31:0] scnt;
        logic [7:0]  sl_left;
        logic        sleeping;
        logic        lp;
        logic        upd;
        gyc_state_e  st;
        logic [6:0]  wp;
        logic [15:0] x;
        logic [15:0] prev;
        logic [15:0] s1o;
        logic [15:0] filt;
        logic [23:0] sum1;
        logic [23:0] sum2;
        logic [15:0] rate;
        logic [15:0] ang;
    } gyc_st_s;
endpackage : gyc_pkg

/* File: core/gyc_mem.sv */
// Simple dual-port memory with registered read data, one delay line of the filter.
// Assumes one clock; contents are undefined until written.
`timescale 1ns/100ps
`default_nettype none
module gyc_mem #(
    parameter int W = 16,
    parameter int D = 128,
    parameter int AW = $clog2(D)
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [W-1:0]  wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [W-1:0]  rdata_o
);
    logic [W-1:0] mem [D];

    if (D != (1 << AW) || W < 1) begin : g_chk
        $error("gyc_mem needs a power-of-two depth.");
    end

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule : gyc_mem
`default_nettype wire

/* File: core/gyc_top.sv */
// Command, sample timing, sleep, filter and calibration logic of the rate sensor, behind its serial port.
// Assumes raw_rate_i is produced on clk_i; the serial pins and the reset pin come from outside.
//
// How it works
// - A one written to a command bit starts its operation; zeros start nothing.
// - Auto-null clears the angle output; it zeroes the rate output via calibration only when the offset was zero before.
// - Auto-null stores the negated current rate output into the offset calibration.
// - Factory restore loads offset 0x000 and scale 0x800.
// - Manual flash update copies nonvolatile registers to flash, busy about 50 ms.
// - Auto-null and factory restore are followed by a flash update.
// - Converter latch command copies the converter register to the output latch.
// - Software reset restarts the processor exactly like the reset pin.
// - Sample period is time base times multiplier plus one.
// - Bit 7 picks time base 1.953 ms or 60.54 ms.
// - Low byte zero means 2048 samples per second and prefilter bypass.
// - Output data refresh at the sample rate, independent of reads.
// - Below 64 samples per second the device runs in low power mode.
// - Nonzero sleep count shuts the device down for count times 0.5 s.
// - Device wakes by itself when the sleep interval ends.
// - Chip select low wakes early; host holds it high to stay asleep.
// - Tap field M sets a filter length of two to the power M.
// - Bartlett filter equals two cascaded N-tap moving averages.
// - Range field 100, 010, 001 selects 320, 160, 80 degrees per second.
// - Range 160 forces taps M of at least 2, range 80 at least 4.
`timescale 1ns/100ps
`default_nettype none
`include "gyc_regs.svh"
module gyc_top import gyc_pkg::*; #(
    parameter int unsigned TB_FAST_CYC = `GYC_TB_FAST_US * `GYC_CLK_MHZ,
    parameter int unsigned TB_SLOW_CYC = `GYC_TB_SLOW_US * `GYC_CLK_MHZ,
    parameter int unsigned FAST_CYC    = (`GYC_CLK_MHZ * 1000000) / `GYC_FAST_SPS,
    parameter int unsigned FLASH_CYC   = `GYC_FLASH_MS * `GYC_CLK_MHZ * 1000,
    parameter int unsigned HALF_CYC    = `GYC_SLP_LSB_MS * `GYC_CLK_MHZ * 1000
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        rst_pin_n_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    input  wire logic [15:0] raw_rate_i,
    output logic             miso_o,
    output logic [15:0]      rate_output_o,
    output logic [15:0]      integrated_angle_output_o,
    output logic [11:0]      dac_o,
    output logic [2:0]       range_o,
    output logic             wide_bw_o,
    output logic             low_power_o,
    output logic             sleep_o,
    output logic             flash_busy_o,
    output logic             sample_o
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    gyc_st_s     s;
    gyc_st_s     n;
    logic [1:0]  rsync;
    logic        rst_n;
    logic        we1;
    logic        we2;
    logic [15:0] wd1;
    logic [15:0] wd2;
    logic [6:0]  ra;
    logic [15:0] rd1;
    logic [15:0] rd2;
    logic [7:0]  cmd;
    logic        srst;
    logic        tick;
    logic        retap;
    logic [7:0]  nt;
    logic [23:0] sum1n;
    logic [23:0] sum2n;
    logic [6:0]  wa;
    logic [7:0]  wd;

    // Products of the period must fit the 32-bit sample counter, and bit 7 alone marks
    // low power only while the slow time base is longer than eight fast ones.
    if (TB_FAST_CYC == 0 || FAST_CYC == 0 || FLASH_CYC == 0 || HALF_CYC == 0
        || TB_SLOW_CYC <= `GYC_LP_MULT * TB_FAST_CYC
        || TB_SLOW_CYC > 32'hffffffff / 128) begin : g_chk
        $error("gyc_top timing parameters out of range.");
    end

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [31:0] per(logic [7:0] sp);
        logic [31:0] b;
        b = sp[`GYC_SP_TB] ? TB_SLOW_CYC : TB_FAST_CYC;
        if (sp == 8'h00) begin
            per = FAST_CYC;
        end else begin
            per = b * ({25'h0, sp[6:0]} + 32'h1);
        end
    endfunction : per

    function automatic logic [3:0] fix_m(logic [2:0] rg, logic [3:0] m);
        logic [3:0] lo;
        lo = (rg == `GYC_RG_80) ? `GYC_MIN_M80 : (rg == `GYC_RG_160) ? `GYC_MIN_M160 : 4'h0;
        fix_m = (m < lo) ? lo : m;
        if (fix_m > `GYC_MAX_M) begin
            fix_m = `GYC_MAX_M;
        end
    endfunction : fix_m

    function automatic logic [15:0] avg(logic [23:0] sm, logic [3:0] m);
        logic [23:0] t;
        t = $signed(sm) >>> m;
        avg = t[15:0];
    endfunction : avg

    function automatic logic [15:0] cal(logic [15:0] f, logic [11:0] m, logic [11:0] b);
        logic signed [29:0] p;
        logic signed [29:0] y;
        p = $signed({{14{f[15]}}, f}) * $signed({18'h0, m});
        y = (p >>> `GYC_CAL_SH) + $signed({{18{b[11]}}, b});
        if (y > $signed(30'h00007fff)) begin
            cal = 16'h7fff;
        end else if (y < $signed(30'h3fff8000)) begin
            cal = 16'h8000;
        end else begin
            cal = y[15:0];
        end
    endfunction : cal

    function automatic logic [11:0] neg12(logic [15:0] r);
        logic signed [16:0] v;
        v = -$signed({r[15], r});
        if (v > $signed(17'h007ff)) begin
            neg12 = 12'h7ff;
        end else if (v < $signed(17'h1f800)) begin
            neg12 = 12'h800;
        end else begin
            neg12 = v[11:0];
        end
    endfunction : neg12

    function automatic logic [15:0] rdmux(logic [6:0] a, gyc_st_s q);
        case ({a[6:1], 1'b0})
            `GYC_A_RATE:  rdmux = q.rate;
            `GYC_A_ANGLE: rdmux = q.ang;
            `GYC_A_OFF:   rdmux = {4'h0, q.off};
            `GYC_A_SCALE: rdmux = {4'h0, q.scl};
            `GYC_A_DAC:   rdmux = {4'h0, q.dac};
            `GYC_A_SMPL:  rdmux = {8'h00, q.smpl};
            `GYC_A_SENS:  rdmux = q.sens;
            `GYC_A_SLP:   rdmux = {8'h00, q.slp};
            default:      rdmux = 16'h0000;
        endcase
    endfunction : rdmux

    // ----------------------------------------
    // Reset release and filter delay lines
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rsync <= 2'h0;
        end else begin
            rsync <= {rsync[0], 1'b1};
        end
    end
    assign rst_n = rsync[1];

    gyc_mem #(.W(16), .D(128)) u_line1 (.clk_i(clk_i), .we_i(we1), .waddr_i(s.wp), .wdata_i(wd1),
        .raddr_i(ra), .rdata_o(rd1));
    gyc_mem #(.W(16), .D(128)) u_line2 (.clk_i(clk_i), .we_i(we2), .waddr_i(s.wp), .wdata_i(wd2),
        .raddr_i(ra), .rdata_o(rd2));

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        n = s;
        we1 = 1'b0;
        we2 = 1'b0;
        wd1 = 16'h0000;
        wd2 = 16'h0000;
        nt = 8'h01 << s.sens[3:0];
        ra = s.wp - nt[6:0];
        cmd = 8'h00;
        tick = 1'b0;
        retap = 1'b0;
        sum1n = 24'h0;
        sum2n = 24'h0;
        wa = s.rx[14:8];
        wd = s.rx[7:0];
        n.sck = {s.sck[1:0], sclk_i};
        n.csn = {s.csn[1:0], cs_n_i};
        n.mosi = {s.mosi[0], mosi_i};
        n.rpin = {s.rpin[0], rst_pin_n_i};
        n.upd = 1'b0;
        n.lp = (s.smpl != 8'h00) && (s.smpl[`GYC_SP_TB] || s.smpl[6:0] >= 7'(`GYC_LP_MULT));
        if (s.fcnt != 32'h0) begin
            n.fcnt = s.fcnt - 32'h1;
        end
        if (s.sleeping) begin
            if (!s.csn[1]) begin
                n.sleeping = 1'b0;
            end else if (s.scnt >= HALF_CYC - 32'h1) begin
                n.scnt = 32'h0;
                n.sl_left = s.sl_left - 8'h01;
                n.sleeping = (s.sl_left > 8'h01);
            end else begin
                n.scnt = s.scnt + 32'h1;
            end
        end else if (s.tcnt >= per(s.smpl) - 32'h1) begin
            n.tcnt = 32'h0;
            tick = 1'b1;
        end else begin
            n.tcnt = s.tcnt + 32'h1;
        end
        unique case (s.st)
            GYC_CLR: begin
                we1 = 1'b1;
                we2 = 1'b1;
                n.wp = s.wp + 7'h01;
                if (s.wp == 7'h7f) begin
                    n.st = GYC_IDLE;
                    n.sum1 = 24'h0;
                    n.sum2 = 24'h0;
                end
            end
            GYC_IDLE: begin
                if (tick) begin
                    // The prefilter averages two samples; fast mode skips it.
                    n.x = (s.smpl == 8'h00) ? raw_rate_i : 16'(({raw_rate_i[15], raw_rate_i}
                          + {s.prev[15], s.prev}) >> 1);
                    n.prev = raw_rate_i;
                    n.st = GYC_S1;
                end
            end
            GYC_S1: begin
                sum1n = s.sum1 + {{8{s.x[15]}}, s.x} - {{8{rd1[15]}}, rd1};
                n.sum1 = sum1n;
                n.s1o = avg(sum1n, s.sens[3:0]);
                we1 = 1'b1;
                wd1 = s.x;
                n.st = GYC_S2;
            end
            GYC_S2: begin
                sum2n = s.sum2 + {{8{s.s1o[15]}}, s.s1o} - {{8{rd2[15]}}, rd2};
                n.sum2 = sum2n;
                n.filt = avg(sum2n, s.sens[3:0]);
                we2 = 1'b1;
                wd2 = s.s1o;
                n.wp = s.wp + 7'h01;
                n.st = GYC_CAL;
            end
            GYC_CAL: begin
                n.rate = cal(s.filt, s.scl, s.off);
                n.ang = s.ang + n.rate;
                n.upd = 1'b1;
                n.st = GYC_IDLE;
            end
        endcase
        // Serial port, mode 3: the first falling clock launches the loaded MSB, later ones shift.
        if (s.csn[2] && !s.csn[1]) begin
            n.bits = 5'h00;
            n.tx = s.rdw;
        end
        if (!s.csn[1] && !s.sck[2] && s.sck[1]) begin
            n.rx = {s.rx[14:0], s.mosi[1]};
            n.bits = (s.bits == 5'h1f) ? s.bits : s.bits + 5'h01;
        end
        if (!s.csn[1] && s.sck[2] && !s.sck[1] && s.bits != 5'h00) begin
            n.tx = {s.tx[14:0], 1'b0};
        end
        if (!s.csn[2] && s.csn[1] && s.bits == `GYC_FRAME) begin
            if (!s.rx[15]) begin
                n.rdw = rdmux(wa, s);
            end else begin
                case (wa)
                    `GYC_A_OFF:          n.off[7:0] = wd;
                    `GYC_A_OFF + 7'h1:   n.off[11:8] = wd[3:0];
                    `GYC_A_SCALE:        n.scl[7:0] = wd;
                    `GYC_A_SCALE + 7'h1: n.scl[11:8] = wd[3:0];
                    `GYC_A_DAC:          n.dac[7:0] = wd;
                    `GYC_A_DAC + 7'h1:   n.dac[11:8] = wd[3:0];
                    `GYC_A_SMPL:         n.smpl = wd;
                    `GYC_A_CMD:          cmd = wd;
                    `GYC_A_SENS: begin
                        n.sens[`GYC_SN_BW] = wd[7];
                        n.sens[3:0] = fix_m(s.sens[10:8], wd[3:0]);
                        retap = 1'b1;
                    end
                    `GYC_A_SENS + 7'h1: begin
                        if (wd[2:0] == `GYC_RG_320 || wd[2:0] == `GYC_RG_160 || wd[2:0] == `GYC_RG_80) begin
                            n.sens[10:8] = wd[2:0];
                            n.sens[3:0] = fix_m(wd[2:0], s.sens[3:0]);
                            retap = 1'b1;
                        end
                    end
                    `GYC_A_SLP: begin
                        n.slp = wd;
                        if (wd != 8'h00) begin
                            n.sleeping = 1'b1;
                            n.sl_left = wd;
                            n.scnt = 32'h0;
                        end
                    end
                    default: ;
                endcase
            end
        end
        // A new filter length invalidates both running sums, so the lines are cleared.
        if (retap) begin
            n.st = GYC_CLR;
            n.wp = 7'h00;
        end
        if (cmd[`GYC_C_DAC]) begin
            n.dacl = s.dac;
        end
        if (cmd[`GYC_C_NULL]) begin
            n.ang = 16'h0000;
            n.off = neg12(s.rate);
            n.fpend = 1'b1;
        end
        if (cmd[`GYC_C_REST]) begin
            n.off = `GYC_OFF_FACT;
            n.scl = `GYC_SCL_FACT;
            n.fpend = 1'b1;
        end
        if (cmd[`GYC_C_FLASH] || s.fpend) begin
            n.nv_off = s.off;
            n.nv_scl = s.scl;
            n.nv_smpl = s.smpl;
            n.nv_sens = s.sens;
            n.fcnt = FLASH_CYC;
            n.fpend = s.fpend ? 1'b0 : n.fpend;
        end
        srst = cmd[`GYC_C_SRST] || !s.rpin[1];
        if (srst) begin
            n.off = s.nv_off;
            n.scl = s.nv_scl;
            n.smpl = s.nv_smpl;
            n.sens = s.nv_sens;
            n.slp = 8'h00;
            n.dac = 12'h000;
            n.dacl = 12'h000;
            n.sleeping = 1'b0;
            n.rate = 16'h0000;
            n.ang = 16'h0000;
            n.fpend = 1'b0;
            n.tcnt = 32'h0;
            n.st = GYC_CLR;
            n.wp = 7'h00;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.sck <= 3'h7;
            s.csn <= 3'h7;
            s.rpin <= 2'h3;
            s.st <= GYC_CLR;
            s.smpl <= `GYC_SMPL_RST;
            s.sens <= `GYC_SENS_RST;
            s.scl <= `GYC_SCL_FACT;
            s.nv_smpl <= `GYC_SMPL_RST;
            s.nv_sens <= `GYC_SENS_RST;
            s.nv_scl <= `GYC_SCL_FACT;
        end else begin
            s <= n;
        end
    end

    assign miso_o = s.tx[15];
    assign rate_output_o = s.rate;
    assign integrated_angle_output_o = s.ang;
    assign dac_o = s.dacl;
    assign range_o = s.sens[10:8];
    assign wide_bw_o = s.sens[`GYC_SN_BW];
    assign low_power_o = s.lp;
    assign sleep_o = s.sleeping;
    assign flash_busy_o = (s.fcnt != 32'h0);
    assign sample_o = s.upd;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic [31:0] gap;
    logic        gv;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 32'h0;
            gv <= 1'b0;
        end else begin
            gap <= tick ? 32'h0 : gap + 32'h1;
            gv <= tick ? 1'b1 : (gv && n.smpl == s.smpl && !s.sleeping && !srst);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    a_tick_period: assert property (tick && gv |-> gap == per(s.smpl) - 32'h1)
        else $error("Sample spacing differs from the programmed period.");
    a_null_effect: assert property (cmd[`GYC_C_NULL] && !cmd[`GYC_C_REST] && !srst
        |=> s.ang == 16'h0 && s.off == neg12($past(s.rate)))
        else $error("Auto-null did not clear angle and negate rate.");
    a_restore_vals: assert property (cmd[`GYC_C_REST] && !srst |=> s.off == 12'h000 && s.scl == 12'h800)
        else $error("Factory restore values wrong.");
    a_flash_follow: assert property ((cmd[`GYC_C_NULL] || cmd[`GYC_C_REST]) && !srst
        |=> ##1 s.fcnt == FLASH_CYC && s.nv_off == $past(s.off))
        else $error("Flash update did not follow calibration command.");
    a_flash_busy: assert property (cmd[`GYC_C_FLASH] && !srst |=> flash_busy_o [*8])
        else $error("Manual flash update not busy.");
    a_dac_latch: assert property (cmd[`GYC_C_DAC] && !srst |=> dac_o == $past(s.dac))
        else $error("Converter latch not loaded.");
    a_srst_reload: assert property (cmd[`GYC_C_SRST] |=> s.st == GYC_CLR && s.off == $past(s.nv_off))
        else $error("Software reset did not restart.");
    a_cs_wake: assert property (s.sleeping && !s.csn[1] |=> !sleep_o)
        else $error("Chip select did not wake the device.");
    a_sleep_halt: assert property (s.sleeping |-> !tick)
        else $error("Sampling continued during sleep.");
    a_tap_min: assert property ((range_o == `GYC_RG_80 |-> s.sens[3:0] >= 4'h4)
        and (range_o == `GYC_RG_160 |-> s.sens[3:0] >= 4'h2))
        else $error("Tap field below range minimum.");
    a_low_power: assert property ($stable(s.smpl) |-> low_power_o
        == (s.smpl != 8'h00 && per(s.smpl) > `GYC_LP_MULT * TB_FAST_CYC))
        else $error("Low power mode does not match sample rate.");

    c_auto_null: cover property (cmd[`GYC_C_NULL] ##[1:4] s.fcnt == FLASH_CYC);
    c_wake_early: cover property (s.sleeping ##1 !s.sleeping && s.sl_left != 8'h00);
    c_fast_sample: cover property (s.smpl == 8'h00 && sample_o);
    c_retap: cover property (s.st == GYC_CLR ##1 s.st == GYC_IDLE);
endmodule : gyc_top
`default_nettype wire

/* File: dv/gyc_host.sv */
// Serial host model for the rate block: mode 3, 16-bit frames, MSB first.
// Assumes the bench calls frame just after a rising clk_i edge.
`timescale 1ns/100ps
`default_nettype none
module gyc_host (
    input  wire logic clk_i,
    input  wire logic miso_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o
);
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // The serial clock stands high between frames; data flips after use so stale bits never pass.
    task automatic frame(input logic [15:0] w, output logic [15:0] r);
        cs_n_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        for (int i = 15; i >= 0; i--) begin
            sclk_o <= 1'b0;
            mosi_o <= w[i];
            repeat (4) @(posedge clk_i);
            r[i] = miso_i;
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
        mosi_o <= ~w[0];
        repeat (5) @(posedge clk_i);
        cs_n_o <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask : frame
endmodule : gyc_host
`default_nettype wire

/* File: dv/gyc_top_bench.sv */
// Self-checking bench of the rate control block behind its serial port.
// Assumes short timing parameters; every expectation is reckoned from them.
`timescale 1ns/100ps
`default_nettype none
module gyc_top_bench;
    logic        clk_i       = 1'b0;
    logic        resetn_i    = 1'b0;
    logic        rst_pin_n_i = 1'b1;
    logic [15:0] raw_rate_i  = 16'h0040;
    logic [15:0] rate, ang, rbuf;
    logic [11:0] dac;
    logic [2:0]  rng;
    logic        wbw, lp, slp, fb, smp, sclk, csn, mosi, miso;
    int          errors = 0, total_checks = 0, cyc = 0;

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            wrap_up();
        end
    end

    gyc_top #(.TB_FAST_CYC(20), .TB_SLOW_CYC(200), .FAST_CYC(10), .FLASH_CYC(50), .HALF_CYC(100)) gyc_top_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .rst_pin_n_i(rst_pin_n_i), .sclk_i(sclk), .cs_n_i(csn),
        .mosi_i(mosi), .raw_rate_i(raw_rate_i), .miso_o(miso), .rate_output_o(rate),
        .integrated_angle_output_o(ang), .dac_o(dac), .range_o(rng), .wide_bw_o(wbw),
        .low_power_o(lp), .sleep_o(slp), .flash_busy_o(fb), .sample_o(smp));
    gyc_host gyc_host_inst (.clk_i(clk_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(csn), .mosi_o(mosi));

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        gyc_host_inst.frame({1'b1, a, d}, rbuf);
    endtask : wr
    // Read data come back in the following frame.
    task automatic rdc(input logic [6:0] a, input logic [15:0] e);
        gyc_host_inst.frame({1'b0, a, 8'h00}, rbuf);
        gyc_host_inst.frame(16'h0000, rbuf);
        chk($sformatf("reg %h", a), e, rbuf);
    endtask : rdc
    task automatic t_reset();
        chk("rng", 16'h0004, 16'(rng));
        rdc(7'h38, 16'h0402);
        rdc(7'h36, 16'h0001);
        rdc(7'h3a, 16'h0000);
        rdc(7'h3e, 16'h0000);
        rdc(7'h20, 16'h0000);
    endtask : t_reset
    task automatic t_restore();
        wr(7'h14, 8'h55);
        wr(7'h3e, 8'h02);
        chk("flash", 16'h0001, 16'(fb));
        rdc(7'h14, 16'h0000);
        rdc(7'h16, 16'h0800);
        chk("flash", 16'h0000, 16'(fb));
    endtask : t_restore
    task automatic t_null();
        repeat (800) @(posedge clk_i);
        chk("rate", 16'h0040, rate);
        wr(7'h3e, 8'h01);
        chk("flash", 16'h0001, 16'(fb));
        repeat (400) @(posedge clk_i);
        chk("rate", 16'h0000, rate);
        chk("angle", 16'h0000, ang);
        rdc(7'h14, 16'h0fc0);
    endtask : t_null
    task automatic t_range();
        wr(7'h39, 8'h01);
        wr(7'h38, 8'h00);
        rdc(7'h38, 16'h0104);
        chk("rng", 16'h0001, 16'(rng));
        wr(7'h39, 8'h03);
        chk("rng", 16'h0001, 16'(rng));
        wr(7'h39, 8'h02);
        wr(7'h38, 8'h89);
        rdc(7'h38, 16'h0287);
        chk("bw", 16'h0001, 16'(wbw));
    endtask : t_range
    // The first two intervals after a write are skipped; the timer may restart.
    task automatic t_per(input logic [7:0] v, input int e, input logic l);
        int n;
        wr(7'h36, v);
        for (n = 0; n < 500 && smp !== 1'b1; n++) @(posedge clk_i);
        repeat (2) begin
            @(posedge clk_i);
            for (n = 1; n < 500 && smp !== 1'b1; n++) @(posedge clk_i);
        end
        chk("period", e[15:0], n[15:0]);
        chk("low_power", 16'(l), 16'(lp));
    endtask : t_per
    task automatic t_dac();
        wr(7'h30, 8'h34);
        wr(7'h31, 8'h02);
        chk("dac", 16'h0000, 16'(dac));
        wr(7'h3e, 8'h74);
        chk("dac", 16'h0234, 16'(dac));
        chk("flash", 16'h0000, 16'(fb));
        wr(7'h3e, 8'h08);
        chk("flash", 16'h0001, 16'(fb));
    endtask : t_dac
    task automatic t_sleep();
        wr(7'h3a, 8'h02);
        repeat (180) @(posedge clk_i);
        chk("sleep", 16'h0001, 16'(slp));
        repeat (30) @(posedge clk_i);
        chk("sleep", 16'h0000, 16'(slp));
        wr(7'h3a, 8'h05);
        chk("sleep", 16'h0001, 16'(slp));
        rdc(7'h3a, 16'h0005);
        chk("sleep", 16'h0000, 16'(slp));
    endtask : t_sleep
    task automatic t_srst();
        wr(7'h3e, 8'h80);
        chk("dac", 16'h0000, 16'(dac));
        rdc(7'h38, 16'h0287);
        wr(7'h30, 8'h11);
        wr(7'h3e, 8'h04);
        chk("dac", 16'h0011, 16'(dac));
        rst_pin_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rst_pin_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("dac", 16'h0000, 16'(dac));
    endtask : t_srst
    task automatic wrap_up();
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        t_reset();
        t_restore();
        t_null();
        t_range();
        t_per(8'h03, 80, 1'b0);
        t_per(8'h07, 160, 1'b0);
        t_per(8'h08, 180, 1'b1);
        t_per(8'h80, 200, 1'b1);
        t_per(8'h00, 10, 1'b0);
        t_dac();
        t_sleep();
        t_srst();
        wrap_up();
    end
endmodule : gyc_top_bench
`default_nettype wire
